// file: hw/flpc_defs.vh
// Register map, field positions, reset values and timing for the FIFO level and power block.
`ifndef FLPC_DEFS_VH
`define FLPC_DEFS_VH

`define FLPC_OFF_RX_DISCARD   8'h78
`define FLPC_OFF_RX_OCC       8'h7c
`define FLPC_OFF_TX_SPACE     8'h80
`define FLPC_OFF_PWR_CTRL     8'h84
`define FLPC_OFF_BYTE_TEST    8'h64

`define FLPC_BIT_FRAME_SKIP   31
`define FLPC_BIT_XCVR_RST     10
`define FLPC_BIT_READY        0
`define FLPC_PS_HI            13
`define FLPC_PS_LO            12

`define FLPC_PS_NORMAL        2'h0
`define FLPC_PS_WAKE_FRAME    2'h1
`define FLPC_PS_ENERGY        2'h2
`define FLPC_PS_RESERVED      2'h3

`define FLPC_TX_FREE_RESET    16'h1200
`define FLPC_RX_USED_RESET    16'h0000
`define FLPC_STAT_USED_RESET  8'h00

`define FLPC_XCVR_RST_US      100
`define FLPC_CLK_MHZ          20
`define FLPC_WAKE_CYCLES      16

`endif

// file: hw/flpc_rd_reg.v
// Registered read-data holder for the host read port.
`timescale 1ns/1ps
`default_nettype none

module flpc_rd_reg #(
	parameter W = 32
) (
	// Clock and reset
	input  wire         ref_clk,
	input  wire         arst_n,
	// Load side
	input  wire         load,
	input  wire [W-1:0] din,
	// Held value
	output reg  [W-1:0] dout
);

	// Captures the selected word on a read so the bus sees a flop output.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dout <= {W{1'b0}};
		end else if (load) begin
			dout <= din;
		end
	end

endmodule // flpc_rd_reg

`default_nettype wire

// file: hw/flpc_regs.v
// FIFO level reporting, frame skip, power state and transceiver reset registers.
`timescale 1ns/1ps
`default_nettype none
`include "flpc_defs.vh"

module flpc_regs #(
	parameter AW         = 8,
	parameter RST_CYCLES = `FLPC_XCVR_RST_US * `FLPC_CLK_MHZ,
	parameter WAKE_CYC   = `FLPC_WAKE_CYCLES
) (
	// Clock and reset
	input  wire          ref_clk,
	input  wire          arst_n,
	// Host register port
	input  wire [AW-1:0] host_addr,
	input  wire          host_wr,
	input  wire          host_rd,
	input  wire [31:0]   host_wdata,
	output wire [31:0]   host_rdata,
	// Receive FIFO side
	input  wire          rx_skip_done,
	input  wire [7:0]    rx_status_words_used,
	input  wire [15:0]   rx_data_bytes_used,
	// Transmit FIFO side
	input  wire [7:0]    tx_status_words_used,
	input  wire [15:0]   tx_data_bytes_free,
	// Core controls
	output reg           rx_frame_skip_req,
	output reg  [1:0]    power_state_sel,
	output reg           transceiver_reset,
	output reg           dev_ready
);

	////////////////////////////////////////////////////////////////////////
	// Local declarations.

	localparam CW = 20;
	localparam [CW-1:0] RST_LOAD  = RST_CYCLES;
	localparam [CW-1:0] WAKE_LOAD = WAKE_CYC;

	reg          frame_skip_r;
	reg  [1:0]   pstate_r;
	reg          xrst_r;
	reg  [CW-1:0] xrst_cnt_r;
	reg  [CW-1:0] wake_cnt_r;
	reg          awake_r;
	reg          unlocked_r;
	reg  [7:0]   rx_sw_r;
	reg  [15:0]  rx_db_r;
	reg  [7:0]   tx_sw_r;
	reg  [15:0]  tx_df_r;
	reg  [31:0]  rd_mux;
	wire         wr_ok;
	wire         wr_disc;
	wire         wr_pwr;
	wire         wr_test;

	////////////////////////////////////////////////////////////////////////
	// Write decode.

	// Discard and power writes count only after a first read and while awake; test-register writes always count.
	assign wr_ok   = host_wr & unlocked_r;
	assign wr_disc = wr_ok & awake_r & (host_addr == `FLPC_OFF_RX_DISCARD);
	assign wr_pwr  = wr_ok & awake_r & (host_addr == `FLPC_OFF_PWR_CTRL);
	assign wr_test = host_wr & (host_addr == `FLPC_OFF_BYTE_TEST);

	////////////////////////////////////////////////////////////////////////
	// Read-before-write lock.

	// Any read unlocks; entering sleep relocks so the host must read after waking.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			unlocked_r <= 1'b0;
		end else if (host_rd) begin
			unlocked_r <= 1'b1;
		end else if (!awake_r) begin
			unlocked_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame skip control.

	// Set by a write of one, held until the receive path reports the skip complete.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_skip_r <= 1'b0;
		end else if (wr_disc & host_wdata[`FLPC_BIT_FRAME_SKIP]) begin
			frame_skip_r <= 1'b1;
		end else if (rx_skip_done) begin
			frame_skip_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state and wake.

	// Entering a reduced state drops ready; a test-register write starts a wake count.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pstate_r   <= `FLPC_PS_NORMAL;
			awake_r    <= 1'b0;
			wake_cnt_r <= WAKE_LOAD;
		end else if (wr_pwr && (host_wdata[`FLPC_PS_HI:`FLPC_PS_LO] == `FLPC_PS_WAKE_FRAME ||
				host_wdata[`FLPC_PS_HI:`FLPC_PS_LO] == `FLPC_PS_ENERGY)) begin
			pstate_r   <= host_wdata[`FLPC_PS_HI:`FLPC_PS_LO];
			awake_r    <= 1'b0;
			wake_cnt_r <= {CW{1'b0}};
		end else if (!awake_r) begin
			if (wake_cnt_r != {CW{1'b0}}) begin
				wake_cnt_r <= wake_cnt_r - {{(CW-1){1'b0}}, 1'b1};
				if (wake_cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
					awake_r  <= 1'b1;
					pstate_r <= `FLPC_PS_NORMAL;
				end
			end else if (wr_test && pstate_r != `FLPC_PS_NORMAL) begin
				wake_cnt_r <= WAKE_LOAD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transceiver reset timer.

	// Writes to the bit are ignored while the reset is already running.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			xrst_r     <= 1'b0;
			xrst_cnt_r <= {CW{1'b0}};
		end else if (xrst_r) begin
			if (xrst_cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
				xrst_r <= 1'b0;
			end
			xrst_cnt_r <= xrst_cnt_r - {{(CW-1){1'b0}}, 1'b1};
		end else if (wr_pwr & host_wdata[`FLPC_BIT_XCVR_RST]) begin
			xrst_r     <= 1'b1;
			xrst_cnt_r <= RST_LOAD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// FIFO level sampling.

	// Levels from the FIFO logic are registered once before they are shown.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sw_r <= `FLPC_STAT_USED_RESET;
			rx_db_r <= `FLPC_RX_USED_RESET;
			tx_sw_r <= `FLPC_STAT_USED_RESET;
			tx_df_r <= `FLPC_TX_FREE_RESET;
		end else begin
			rx_sw_r <= rx_status_words_used;
			rx_db_r <= rx_data_bytes_used;
			tx_sw_r <= tx_status_words_used;
			tx_df_r <= tx_data_bytes_free;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer.

	// Reserved and unmapped bits read zero; power control answers even when asleep.
	always @* begin
		rd_mux = 32'h0;
		case (host_addr)
			`FLPC_OFF_RX_DISCARD: begin
				rd_mux[`FLPC_BIT_FRAME_SKIP] = frame_skip_r;
			end
			`FLPC_OFF_RX_OCC: begin
				rd_mux[23:16] = rx_sw_r;
				rd_mux[15:0]  = rx_db_r;
			end
			`FLPC_OFF_TX_SPACE: begin
				rd_mux[23:16] = tx_sw_r;
				rd_mux[15:0]  = tx_df_r;
			end
			`FLPC_OFF_PWR_CTRL: begin
				rd_mux[`FLPC_PS_HI:`FLPC_PS_LO] = pstate_r;
				rd_mux[`FLPC_BIT_XCVR_RST]      = xrst_r;
				rd_mux[`FLPC_BIT_READY]         = awake_r;
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	// Read data is held in a register and appears the cycle after the read strobe.
	flpc_rd_reg #(
		.W (32)
	) u_rd (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.load    (host_rd),
		.din     (rd_mux),
		.dout    (host_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Control outputs.

	// Registered copies drive the core so every output comes from a flop.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_frame_skip_req <= 1'b0;
			power_state_sel   <= `FLPC_PS_NORMAL;
			transceiver_reset <= 1'b0;
			dev_ready         <= 1'b0;
		end else begin
			rx_frame_skip_req <= frame_skip_r;
			power_state_sel   <= pstate_r;
			transceiver_reset <= xrst_r;
			dev_ready         <= awake_r;
		end
	end

endmodule // flpc_regs

`default_nettype wire

// file: test/flpc_regs_props.sv
// Assertion checker for the FIFO level and power registers.
`timescale 1ns/1ps
`default_nettype none
module flpc_regs_props #(
	parameter RST_CYCLES = 5
) (
	// Clock, reset and host port
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic [7:0]  host_addr,
	input wire logic        host_rd,
	input wire logic [31:0] host_rdata,
	// Skip completion and FIFO levels
	input wire logic        rx_skip_done,
	input wire logic [7:0]  rx_status_words_used,
	input wire logic [15:0] rx_data_bytes_used,
	input wire logic [7:0]  tx_status_words_used,
	input wire logic [15:0] tx_data_bytes_free,
	// Core controls
	input wire logic        rx_frame_skip_req,
	input wire logic [1:0]  power_state_sel,
	input wire logic        transceiver_reset,
	input wire logic        dev_ready
);
	logic [15:0] hi_cnt_r;
	// Counts how long the transceiver reset has been held.
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n) hi_cnt_r <= '0;
		else hi_cnt_r <= transceiver_reset ? hi_cnt_r + 16'h1 : 16'h0;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	skip_hold_a: assert property (rx_frame_skip_req && !rx_skip_done && !$past(rx_skip_done)
		|=> rx_frame_skip_req) else $error("skip request dropped early");
	skip_clear_a: assert property (rx_skip_done |-> ##2 !rx_frame_skip_req)
		else $error("skip request not cleared");
	xcvr_min_a: assert property ($fell(transceiver_reset) |-> hi_cnt_r >= RST_CYCLES)
		else $error("transceiver reset too short");
	xcvr_max_a: assert property (transceiver_reset |-> hi_cnt_r < RST_CYCLES + 2)
		else $error("transceiver reset not released");
	sleep_busy_a: assert property (power_state_sel != 2'h0 ##1 power_state_sel != 2'h0
		|-> !dev_ready) else $error("ready while asleep");
	ps_legal_a: assert property (power_state_sel != 2'h3) else $error("reserved power state");
	rd_hold_a: assert property (!$past(host_rd) |-> $stable(host_rdata))
		else $error("read data changed without read");
	rx_info_a: assert property (host_rd && host_addr == 8'h7c && $stable(rx_data_bytes_used)
		&& $stable(rx_status_words_used) |=> host_rdata == {8'h00,
		$past(rx_status_words_used), $past(rx_data_bytes_used)}) else $error("rx info wrong");
	tx_info_a: assert property (host_rd && host_addr == 8'h80 && $stable(tx_data_bytes_free)
		&& $stable(tx_status_words_used) |=> host_rdata == {8'h00,
		$past(tx_status_words_used), $past(tx_data_bytes_free)}) else $error("tx info wrong");
endmodule // flpc_regs_props
bind flpc_regs flpc_regs_props #(.RST_CYCLES(RST_CYCLES)) u_props (.*);
`default_nettype wire

// file: test/tb_flpc_regs.sv
// Self-checking bench for the FIFO level and power registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_flpc_regs;
	localparam RC = 5;
	logic        ref_clk = 1'h0, arst_n = 1'h0, host_wr = 1'h0, host_rd = 1'h0, rx_skip_done = 1'h0;
	logic [7:0]  host_addr = '0, rx_status_words_used = '0, tx_status_words_used = '0;
	logic [15:0] rx_data_bytes_used = '0, tx_data_bytes_free = 16'h1200;
	logic [31:0] host_wdata = '0, host_rdata, rv;
	logic        rx_frame_skip_req, transceiver_reset, dev_ready;
	logic [1:0]  power_state_sel;
	integer      err_total = 0, tests_run = 0, seed = 32'h92b5da19, i;
	flpc_regs #(.RST_CYCLES(RC), .WAKE_CYC(2)) DUT (.*);
	// Free-running 20 MHz clock.
	initial forever #25 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk) #1;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'h1;
		@(posedge ref_clk) #1 host_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk) #1;
		host_addr = a;
		host_rd = 1'h1;
		@(posedge ref_clk) #1 host_rd = 1'h0;
		@(posedge ref_clk) #1 rv = host_rdata;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence: levels, frame skip, transceiver reset, sleep and wake.
	initial begin
		cyc(12);
		arst_n = 1'h1;
		i = 0;
		do begin rd(8'h84); i++; end while (rv[0] !== 1'b1 && i < 20);
		`CHK("ready", 32'h1, rv)
		rd(8'h78);
		`CHK("discard", 32'h0, rv)
		for (i = 0; i < 8; i++) begin
			{rx_status_words_used, rx_data_bytes_used} = i ? 24'($random(seed)) : 24'hffffff;
			// The bench pushes no transmit data, so it never exceeds the free count.
			{tx_status_words_used, tx_data_bytes_free} = 24'($random(seed));
			cyc(2);
			rd(8'h7c);
			`CHK("rxinfo", {8'h0, rx_status_words_used, rx_data_bytes_used}, rv)
			rd(8'h80);
			`CHK("txinfo", {8'h0, tx_status_words_used, tx_data_bytes_free}, rv)
		end
		wr(8'h78, 32'hffffffff);
		cyc(4);
		rd(8'h78);
		`CHK("skip", 32'h80000000, rv)
		`CHK("skipreq", 1'b1, rx_frame_skip_req)
		// No receive data is read while the skip bit is high.
		rx_skip_done = 1'h1;
		cyc(1);
		rx_skip_done = 1'h0;
		rd(8'h78);
		`CHK("skipdone", 32'h0, rv)
		wr(8'h84, 32'h400);
		rd(8'h84);
		`CHK("xrst", 32'h401, rv)
		`CHK("xrstpin", 1'b1, transceiver_reset)
		wr(8'h84, 32'h400);
		cyc(RC - 2);
		rd(8'h84);
		`CHK("xrstend", 32'h1, rv)
		for (i = 1; i < 3; i++) begin
			wr(8'h84, 32'(i << 12));
			cyc(2);
			wr(8'h78, 32'h80000000);
			rd(8'h84);
			`CHK("sleep", 32'(i << 12), rv)
			`CHK("pssel", 2'(i), power_state_sel)
			rd(8'h78);
			`CHK("locked", 32'h0, rv)
			wr(8'h64, 32'($random(seed)));
			for (int k = 0; k < 40 && dev_ready !== 1'b1; k++) cyc(1);
			wr(8'h78, 32'h80000000);
			rd(8'h78);
			`CHK("firstwr", 32'h0, rv)
			rd(8'h84);
			`CHK("wake", 32'h1, rv)
		end
		wr(8'h84, 32'h3000);
		rd(8'h84);
		`CHK("ps11", 32'h1, rv)
		summarize();
	end
	// Watchdog against a hang.
	initial begin
		#100000;
		err_total++;
		summarize();
	end
endmodule // tb_flpc_regs
`default_nettype wire
